// *** hw/ctx_image_regs.vh ***
`ifndef CTX_IMAGE_REGS_VH
`define CTX_IMAGE_REGS_VH

// ****************************************************************
// APB register map (byte addresses)
// ****************************************************************
`define CTL_OFS 12'h000
`define STATUS_OFS 12'h004
`define IMAGE_BASE_OFS 12'h008
`define POWER_BASE_OFS 12'h00C
`define SWITCH_OFS 12'h010
`define LIVE_OFS 12'h400
`define LIVE_END 12'h900

// Control bits
`define CTL_SAVE_LOG 0
`define CTL_RESTORE_LOG 1
`define CTL_SAVE_PWR 2
`define CTL_RESTORE_PWR 3
`define CTL_ISSUE_BTP 8
`define CTL_ISSUE_CB 9
`define CTL_CLEAR_ISSUED 10

// Context switch word fields
`define SW_EXT_SAVE 3
`define SW_EXT_RESTORE 2
`define SW_FORCE 1
`define SW_ADDR_MASK 32'hFFFFF800
`define SWITCH_RESET 32'h00000000

// ****************************************************************
// Image slot indices (dwords)
// ****************************************************************
`define SLOT_BTP_HDR 9'h06F
`define SLOT_BTP_LAST 9'h074
`define SLOT_CB_HDR 9'h075
`define SLOT_CB_DATA 9'h076
`define SLOT_RSV_FIRST 9'h077
`define SLOT_RSV_LAST 9'h087
`define SLOT_IDX_HDR 9'h088
`define SLOT_VB_HDR 9'h08B
`define SLOT_VE_HDR 9'h0D0
`define SLOT_STATS 9'h0F5
`define SLOT_BASE_LAST 9'h0FF
`define SLOT_PAL_HDR 9'h100
`define SLOT_STIP_HDR 9'h118
`define SLOT_STIP_LAST 9'h138
`define SLOT_EXT_LAST 9'h13F
`define SLOT_PWR_LAST 9'h00F
`define SLOT_COUNT 320

// Power image slots
`define PS_LRI_HDR 9'h001
`define PS_SCRATCH_OFS 9'h002
`define PS_CC_OFS 9'h004
`define PS_CC_DATA 9'h005
`define PS_TAIL_OFS 9'h006
`define PS_TAIL_DATA 9'h007
`define PS_START_OFS 9'h008
`define PS_START_DATA 9'h009
`define PS_HEAD_OFS 9'h00A
`define PS_HEAD_DATA 9'h00B
`define PS_LEN_OFS 9'h00C
`define PS_LEN_DATA 9'h00D
`define PS_SWITCH_HDR 9'h00E
`define PS_SWITCH_DATA 9'h00F

// ****************************************************************
// Command encodings
// ****************************************************************
`define NOOP_WORD 32'h00000000
`define PIPE_TYPE 3'h3
`define PIPE_3D 2'h3
`define PIPE_CB 2'h0
`define OPC_PIPELINED 3'h0
`define OPC_NONPIPE 3'h1
`define SUB_BTP 8'h01
`define SUB_CB 8'h02
`define SUB_IDX 8'h0A
`define SUB_VB 8'h08
`define SUB_VE 8'h09
`define SUB_STATS 8'h0B
`define SUB_PAL 8'h02
`define SUB_STIP 8'h07
`define LEN_BTP 8'h04
`define LEN_IDX 8'h01
`define LEN_STIP 16'h001F
`define CB_VALID_BIT 8
`define MI_TYPE 3'h0
`define MI_OPC_LRI 6'h22
`define MI_OPC_SWITCH 6'h18
`define LRI_BWD 4'hF
`define LRI_LEN 6'h0A
`define CC_WMASK 5'h1F
`define PTR_MASK 32'hFFFFFFE0
`define CB_PTR_MASK 32'hFFFFFFFF
`define START_MASK 32'hFFFFF000
`define HEAD_MASK 32'hFFFFFFFC
`define RLEN_MASK 32'h001FFF07

// Ring register offsets placed in the image (arbitrary values)
`define REG_SCRATCH 32'h00000100
`define REG_CC 32'h00000104
`define REG_TAIL 32'h00000108
`define REG_START 32'h0000010C
`define REG_HEAD 32'h00000110
`define REG_RLEN 32'h00000114

`endif

// *** hw/ctx_image.v ***
`timescale 1ns/1ns
// Behaviour
// - Binding table slots are no-ops until that command was issued, and again after a clear.
// - Shader constant pointer slots are no-ops until that command was issued.
// - Constant pointer header valid bit 8 set only when issued.
// - Palette command and entries from dword 100h saved only in extended mode.
// - Stipple command, length 31, 32 rows top to bottom, only extended.
// - Power image writes the ring tail offset but never saves the ring tail value.
// - Saved ring tail in-use bit always zero.
// - Ring head restored after ring start, since start resets head.
// - Power image opens with no-op then register load 22h, Fh, Ah.
// - Condition codes saved in 4:0 with write mask 1Fh in 20:16.
// - Switch command 18h length 0, then address, ext save, restore, force.
// - Ring length slot holds length, wait, arb, slice, disable, report, enable.
// - Index header subopcode 0Ah, cut bit 10, format 9:8, length 1.
// - Statistics at F5h subopcode 0Bh enable bit 0, no-ops through FFh.
// - Seventeen vertex buffer states of four dwords after header 08h.
// - Binding header subopcode 01h length 4, five pointers in 31:5.
// - Power image restore after reset reloads every saved slot, but the ring tail value comes back as zero.
// - Palette and stipple saved on ext save, restored on ext restore.
`include "ctx_image_regs.vh"

module ctx_image (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg mem_req,
    output reg mem_we,
    output reg [31:0] mem_addr,
    output reg [31:0] mem_wdata,
    input wire mem_ack,
    input wire [31:0] mem_rdata
);

    // ****************************************************************
    // States and storage
    // ****************************************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_ISSUE = 3'b010;
    localparam [2:0] ST_WAIT = 3'b100;

    reg [2:0] state;
    reg [8:0] slot;
    reg [8:0] last_slot;
    reg op_restore;
    reg op_power;
    reg btp_issued;
    reg cb_issued;
    reg done;
    reg [31:0] image_base;
    reg [31:0] power_base;
    reg [31:0] switch_word;
    reg [31:0] live [0:`SLOT_COUNT-1];
    reg [31:0] next_word;
    reg [31:0] rd_value;
    reg rd_hit;

    wire [31:0] live_at_slot;
    wire [11:0] ofs;
    wire [11:0] live_rel;
    wire [8:0] live_idx;
    wire in_live;
    wire apb_setup;
    wire apb_commit;
    wire ext_save;
    wire ext_restore;
    wire busy;
    integer i;

    // Pipelined command header builder
    function [31:0] pipe_hdr;
        input [1:0] pipe;
        input [2:0] opc;
        input [7:0] sub;
        begin
            pipe_hdr = {`PIPE_TYPE, pipe, opc, sub, 16'h0000};
        end
    endfunction

    // Memory interface command header builder
    function [31:0] mi_hdr;
        input [5:0] opc;
        begin
            mi_hdr = {`MI_TYPE, opc, 23'h000000};
        end
    endfunction

    // Bus decode
    assign ofs = paddr[11:0];
    assign live_rel = ofs - `LIVE_OFS;
    assign live_idx = live_rel[10:2];
    assign in_live = (ofs >= `LIVE_OFS) && (ofs < `LIVE_END) && (paddr[31:12] == 20'h00000);
    assign apb_setup = psel && penable && !pready;
    assign apb_commit = psel && penable && pready;
    assign ext_save = switch_word[`SW_EXT_SAVE];
    assign ext_restore = switch_word[`SW_EXT_RESTORE];
    assign busy = (state != ST_IDLE);
    assign live_at_slot = live[slot];

    // ****************************************************************
    // Image word for the current slot
    // ****************************************************************
    always @* begin
        next_word = `NOOP_WORD;
        if (op_power) begin
            if (slot == `PS_LRI_HDR) begin
                next_word = mi_hdr(`MI_OPC_LRI) | {20'h00000, `LRI_BWD, 2'b00, `LRI_LEN};
            end else if (slot == `PS_SCRATCH_OFS) begin
                next_word = `REG_SCRATCH;
            end else if (slot == `PS_CC_OFS) begin
                next_word = `REG_CC;
            end else if (slot == `PS_CC_DATA) begin
                next_word = {11'h000, `CC_WMASK, 11'h000, live_at_slot[4:0]};
            end else if (slot == `PS_TAIL_OFS) begin
                next_word = `REG_TAIL;
            end else if (slot == `PS_TAIL_DATA) begin
                next_word = `NOOP_WORD;
            end else if (slot == `PS_START_OFS) begin
                next_word = `REG_START;
            end else if (slot == `PS_START_DATA) begin
                next_word = live_at_slot & `START_MASK;
            end else if (slot == `PS_HEAD_OFS) begin
                next_word = `REG_HEAD;
            end else if (slot == `PS_HEAD_DATA) begin
                next_word = live_at_slot & `HEAD_MASK;
            end else if (slot == `PS_LEN_OFS) begin
                next_word = `REG_RLEN;
            end else if (slot == `PS_LEN_DATA) begin
                next_word = live_at_slot & `RLEN_MASK;
            end else if (slot == `PS_SWITCH_HDR) begin
                next_word = mi_hdr(`MI_OPC_SWITCH);
            end else if (slot == `PS_SWITCH_DATA) begin
                next_word = (switch_word & `SW_ADDR_MASK) | {28'h0000000,
                    switch_word[`SW_EXT_SAVE], switch_word[`SW_EXT_RESTORE],
                    switch_word[`SW_FORCE], 1'b0};
            end else if (slot == 9'h003) begin
                next_word = live_at_slot;
            end
        end else begin
            if (slot == `SLOT_BTP_HDR) begin
                next_word = btp_issued ?
                    (pipe_hdr(`PIPE_3D, `OPC_PIPELINED, `SUB_BTP) | {24'h000000, `LEN_BTP}) :
                    `NOOP_WORD;
            end else if (slot > `SLOT_BTP_HDR && slot <= `SLOT_BTP_LAST) begin
                next_word = btp_issued ? (live_at_slot & `PTR_MASK) : `NOOP_WORD;
            end else if (slot == `SLOT_CB_HDR) begin
                next_word = cb_issued ?
                    (pipe_hdr(`PIPE_CB, `OPC_PIPELINED, `SUB_CB) | (32'h1 << `CB_VALID_BIT)) :
                    `NOOP_WORD;
            end else if (slot == `SLOT_CB_DATA) begin
                next_word = cb_issued ? (live_at_slot & `CB_PTR_MASK) : `NOOP_WORD;
            end else if (slot >= `SLOT_RSV_FIRST && slot <= `SLOT_RSV_LAST) begin
                next_word = `NOOP_WORD;
            end else if (slot == `SLOT_IDX_HDR) begin
                next_word = pipe_hdr(`PIPE_3D, `OPC_PIPELINED, `SUB_IDX) |
                    {21'h00000, live_at_slot[10:8], `LEN_IDX};
            end else if (slot == `SLOT_VB_HDR) begin
                next_word = pipe_hdr(`PIPE_3D, `OPC_PIPELINED, `SUB_VB) |
                    {24'h000000, live_at_slot[7:0]};
            end else if (slot == `SLOT_VE_HDR) begin
                next_word = pipe_hdr(`PIPE_3D, `OPC_PIPELINED, `SUB_VE) |
                    {24'h000000, live_at_slot[7:0]};
            end else if (slot == `SLOT_STATS) begin
                next_word = pipe_hdr(`PIPE_3D, `OPC_PIPELINED, `SUB_STATS) |
                    {31'h0000000, live_at_slot[0]};
            end else if (slot > `SLOT_STATS && slot <= `SLOT_BASE_LAST) begin
                next_word = `NOOP_WORD;
            end else if (slot == `SLOT_PAL_HDR) begin
                next_word = pipe_hdr(`PIPE_3D, `OPC_NONPIPE, `SUB_PAL) |
                    {28'h0000000, live_at_slot[3:0]};
            end else if (slot == `SLOT_STIP_HDR) begin
                next_word = pipe_hdr(`PIPE_3D, `OPC_NONPIPE, `SUB_STIP) | {16'h0000, `LEN_STIP};
            end else if (slot > `SLOT_STIP_LAST) begin
                next_word = `NOOP_WORD;
            end else begin
                next_word = live_at_slot;
            end
        end
    end

    // ****************************************************************
    // APB read mux
    // ****************************************************************
    always @* begin
        rd_value = 32'h00000000;
        rd_hit = 1'b1;
        if (in_live) begin
            rd_value = live[live_idx];
        end else if (ofs == `CTL_OFS && paddr[31:12] == 20'h00000) begin
            rd_value = 32'h00000000;
        end else if (ofs == `STATUS_OFS && paddr[31:12] == 20'h00000) begin
            rd_value = {7'h00, slot, 12'h000, cb_issued, btp_issued, done, busy};
        end else if (ofs == `IMAGE_BASE_OFS && paddr[31:12] == 20'h00000) begin
            rd_value = image_base;
        end else if (ofs == `POWER_BASE_OFS && paddr[31:12] == 20'h00000) begin
            rd_value = power_base;
        end else if (ofs == `SWITCH_OFS && paddr[31:12] == 20'h00000) begin
            rd_value = switch_word;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // APB answer: one wait cycle in each access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (apb_setup) begin
            pready <= 1'b1;
            pslverr <= !rd_hit;
            prdata <= pwrite ? 32'h00000000 : rd_value;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    // ****************************************************************
    // Control registers and sequencer
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            slot <= 9'h000;
            last_slot <= 9'h000;
            op_restore <= 1'b0;
            op_power <= 1'b0;
            btp_issued <= 1'b0;
            cb_issued <= 1'b0;
            done <= 1'b0;
            image_base <= 32'h00000000;
            power_base <= 32'h00000000;
            switch_word <= `SWITCH_RESET;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h00000000;
            mem_wdata <= 32'h00000000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (apb_commit && pwrite && ofs == `CTL_OFS) begin
                        if (pwdata[`CTL_CLEAR_ISSUED]) begin
                            btp_issued <= 1'b0;
                            cb_issued <= 1'b0;
                        end
                        if (pwdata[`CTL_ISSUE_BTP]) begin
                            btp_issued <= 1'b1;
                        end
                        if (pwdata[`CTL_ISSUE_CB]) begin
                            cb_issued <= 1'b1;
                        end
                        if (pwdata[`CTL_SAVE_PWR] || pwdata[`CTL_RESTORE_PWR]) begin
                            state <= ST_ISSUE;
                            done <= 1'b0;
                            op_power <= 1'b1;
                            op_restore <= pwdata[`CTL_RESTORE_PWR];
                            slot <= 9'h000;
                            last_slot <= `SLOT_PWR_LAST;
                        end else if (pwdata[`CTL_SAVE_LOG] || pwdata[`CTL_RESTORE_LOG]) begin
                            state <= ST_ISSUE;
                            done <= 1'b0;
                            op_power <= 1'b0;
                            op_restore <= pwdata[`CTL_RESTORE_LOG];
                            slot <= `SLOT_BTP_HDR;
                            // extended areas gated by switch bits
                            if (pwdata[`CTL_RESTORE_LOG]) begin
                                last_slot <= ext_restore ? `SLOT_EXT_LAST : `SLOT_BASE_LAST;
                            end else begin
                                last_slot <= ext_save ? `SLOT_EXT_LAST : `SLOT_BASE_LAST;
                            end
                        end
                    end else if (apb_commit && pwrite && ofs == `IMAGE_BASE_OFS) begin
                        image_base <= {pwdata[31:2], 2'b00};
                    end else if (apb_commit && pwrite && ofs == `POWER_BASE_OFS) begin
                        power_base <= {pwdata[31:2], 2'b00};
                    end else if (apb_commit && pwrite && ofs == `SWITCH_OFS) begin
                        switch_word <= pwdata;
                    end
                end
                ST_ISSUE: begin
                    mem_req <= 1'b1;
                    mem_we <= !op_restore;
                    mem_addr <= (op_power ? power_base : image_base) + {21'h00000, slot, 2'b00};
                    mem_wdata <= op_restore ? 32'h00000000 : next_word;
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        if (op_restore && !op_power && slot == `SLOT_BTP_HDR) begin
                            btp_issued <= (mem_rdata != `NOOP_WORD);
                        end
                        if (op_restore && !op_power && slot == `SLOT_CB_HDR) begin
                            cb_issued <= (mem_rdata != `NOOP_WORD);
                        end
                        if (op_restore && op_power && slot == `PS_SWITCH_DATA) begin
                            switch_word <= mem_rdata;
                        end
                        if (slot == last_slot) begin
                            state <= ST_IDLE;
                            done <= 1'b1;
                        end else begin
                            slot <= slot + 9'h001;
                            state <= ST_ISSUE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Live state store, written by APB or by restore
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < `SLOT_COUNT; i = i + 1) begin
                live[i] <= 32'h00000000;
            end
        end else if (state == ST_WAIT && mem_ack && op_restore) begin
            live[slot] <= mem_rdata;
            // start restore clears head; head slot comes later
            if (op_power && slot == `PS_START_DATA) begin
                live[`PS_HEAD_DATA] <= 32'h00000000;
            end
        end else if (apb_commit && pwrite && in_live && !busy) begin
            live[live_idx] <= pwdata;
        end
    end

endmodule

// *** sim/ctx_image_checker.sv ***
`timescale 1ns/1ns
module ctx_image_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    input wire mem_req,
    input wire mem_we,
    input wire mem_ack,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire [31:0] mem_addr,
    input wire [31:0] mem_wdata,
    input wire [31:0] mem_rdata
);
    reg [31:0] last_addr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Address of the last acknowledged slot
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) last_addr <= 32'h0;
        else if (mem_req && mem_ack) last_addr <= mem_addr;
    end
    sequence s_gap;
        (mem_req && mem_ack) ##1 !mem_req ##1 mem_req;
    endsequence
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
        && $stable(mem_we) && $stable(mem_wdata)) else $error("memory request moved");
    req_gap_a: assert property (mem_req && mem_ack |=> !mem_req) else $error("no idle cycle");
    read_zero_a: assert property (mem_req && !mem_we |-> mem_wdata == 32'h0)
        else $error("read carries data");
    step_up_a: assert property (s_gap |-> mem_addr == last_addr + 32'h4)
        else $error("slot order broken");
endmodule
bind ctx_image ctx_image_checker ctx_image_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_ack(mem_ack), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

// *** sim/mem_model.sv ***
`timescale 1ns/1ns
module mem_model (
    input wire pclk,
    input wire presetn,
    input wire slow,
    input wire mem_req,
    input wire mem_we,
    input wire [31:0] mem_addr,
    input wire [31:0] mem_wdata,
    output reg mem_ack,
    output reg [31:0] mem_rdata
);
    reg [31:0] m [0:4095];
    reg [2:0] wait_cnt;
    // One word per request, prompt or after a stall; idle data toggles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_cnt <= 3'h0;
            mem_rdata <= 32'h0;
        end else if (mem_req && !mem_ack && wait_cnt >= (slow ? 3'h3 : 3'h0)) begin
            mem_ack <= 1'b1;
            wait_cnt <= 3'h0;
            if (mem_we) m[mem_addr[13:2]] <= mem_wdata;
            else mem_rdata <= m[mem_addr[13:2]];
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule

// *** sim/test_ctx_image.sv ***
`timescale 1ns/1ns
`include "ctx_image_regs.vh"
module test_ctx_image;
    reg pclk, presetn, psel, penable, pwrite, slow, e;
    reg [31:0] paddr, pwdata, q;
    wire pready, pslverr, mem_req, mem_we, mem_ack;
    wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
    integer err_count, check_count, i;
    ctx_image ctx_image_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    mem_model mem_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function [31:0] lv(input integer s);
        lv = {s[15:0], 16'h0701};
    endfunction
    // Saved logical image word at a slot
    function [31:0] img(input integer s);
        img = mem_model_inst.m[32'h400 + s];
    endfunction
    task results;
        begin
            $display("checks %0d mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input reg [31:0] got, input reg [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // APB master, called right after a rising edge
    task apb(input reg w, input reg [31:0] a, input reg [31:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task live(input integer s, input reg [31:0] d);
        apb(1'b1, 32'h400 + s * 4, d);
    endtask
    task run(input reg [31:0] c);
        begin
            apb(1'b1, `CTL_OFS, c);
            q = 32'h1;
            while (q[0] !== 1'b0) begin
                apb(1'b0, `STATUS_OFS, 32'h0);
            end
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_unmapped;
        begin
            apb(1'b0, 32'h20, 32'h0);
            chk({31'h0, e}, 32'h1);
            chk(q, 32'h0);
            $display("unmapped done");
        end
    endtask
    task t_plain;
        begin
            for (i = 32'h6F; i <= 32'h13F; i = i + 1) live(i, lv(i));
            for (i = 32'h6F; i <= 32'h13F; i = i + 1)
                mem_model_inst.m[32'h400 + i] = 32'hA5A5A5A5;
            apb(1'b1, `IMAGE_BASE_OFS, 32'h1000);
            apb(1'b1, `SWITCH_OFS, 32'h0);
            run(32'h1);
            for (i = 32'h6F; i <= 32'h76; i = i + 1) chk(img(i), 32'h0);
            chk(mem_model_inst.m[32'h488], 32'h780A0701);
            chk(mem_model_inst.m[32'h48A], lv(32'h8A));
            chk(mem_model_inst.m[32'h4F5], 32'h780B0001);
            for (i = 32'hF6; i <= 32'hFF; i = i + 1) chk(img(i), 32'h0);
            for (i = 32'h100; i <= 32'h13F; i = i + 1) chk(img(i), 32'hA5A5A5A5);
            $display("plain save done");
        end
    endtask
    // Reserved slots 77h..87h are never compared
    // content is always a no-op
    task t_ext;
        begin
            run(32'h300);
            apb(1'b1, `SWITCH_OFS, 32'h8);
            run(32'h1);
            chk(mem_model_inst.m[32'h46F], 32'h78010004);
            for (i = 32'h70; i <= 32'h74; i = i + 1) chk(img(i), lv(i) & 32'hFFFFFFE0);
            chk(mem_model_inst.m[32'h475], 32'h60020100);
            chk(mem_model_inst.m[32'h48B] & 32'hFFFFFF00, 32'h78080000);
            for (i = 32'h8C; i <= 32'hCF; i = i + 1) chk(img(i), lv(i));
            chk(mem_model_inst.m[32'h500] & 32'hFFFFFFF0, 32'h79020000);
            chk(mem_model_inst.m[32'h518], 32'h7907001F);
            for (i = 32'h119; i <= 32'h138; i = i + 1) chk(img(i), lv(i));
            $display("extended save done");
        end
    endtask
    task t_power;
        begin
            for (i = 0; i <= 32'hF; i = i + 1) live(i, 32'hFFFFFFFF);
            apb(1'b1, `POWER_BASE_OFS, 32'h2000);
            apb(1'b1, `SWITCH_OFS, 32'h1234500E);
            run(32'h4);
            chk(mem_model_inst.m[32'h800], 32'h0);
            chk(mem_model_inst.m[32'h801], 32'h11000F0A);
            chk(mem_model_inst.m[32'h802], `REG_SCRATCH);
            chk(mem_model_inst.m[32'h805], 32'h001F001F);
            chk(mem_model_inst.m[32'h807], 32'h0);
            chk(mem_model_inst.m[32'h809], 32'hFFFFF000);
            chk(mem_model_inst.m[32'h80D], 32'h001FFF07);
            chk(mem_model_inst.m[32'h80E], 32'h0C000000);
            chk(mem_model_inst.m[32'h80F], 32'h1234500E);
            $display("power save done");
        end
    endtask
    task t_restore;
        begin
            slow <= 1'b1;
            mem_model_inst.m[32'h809] = 32'hABCDE000;
            mem_model_inst.m[32'h80B] = 32'h00012344;
            run(32'h8);
            apb(1'b0, 32'h42C, 32'h0);
            chk(q, 32'h00012344);
            apb(1'b0, 32'h424, 32'h0);
            chk(q, 32'hABCDE000);
            mem_model_inst.m[32'h489] = 32'h24681357;
            mem_model_inst.m[32'h519] = 32'h13572468;
            apb(1'b1, `SWITCH_OFS, 32'h0);
            run(32'h2);
            apb(1'b0, 32'h624, 32'h0);
            chk(q, 32'h24681357);
            apb(1'b0, 32'h864, 32'h0);
            chk(q, lv(32'h119));
            apb(1'b1, `SWITCH_OFS, 32'h4);
            run(32'h2);
            chk(q & 32'hC, 32'hC);
            apb(1'b0, 32'h864, 32'h0);
            chk(q, 32'h13572468);
            run(32'h400);
            chk(q & 32'hC, 32'h0);
            slow <= 1'b0;
            $display("restore done");
        end
    endtask
    // Clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge pclk);
        err_count = err_count + 1;
        results;
    end
    // Main sequence
    initial begin
        err_count = 0;
        check_count = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_unmapped;
        t_plain;
        t_ext;
        t_power;
        t_restore;
        results;
    end
endmodule
